// ==== design/pgce_defines.svh ====
// timing counts, field positions and reset values for the pin capture/event block
`ifndef PGCE_DEFINES_SVH
`define PGCE_DEFINES_SVH
`define PGCE_CLK_PERIOD_NS  10
`define PGCE_STABLE_NS      40
`define PGCE_STABLE_CYC     ((`PGCE_STABLE_NS / `PGCE_CLK_PERIOD_NS) + 1)
`define PGCE_PULSE_NS       100
`define PGCE_PULSE_CYC      (`PGCE_PULSE_NS / `PGCE_CLK_PERIOD_NS)
`define PGCE_OUT_LAT_NS     40
`define PGCE_OUT_LAT_CYC    (`PGCE_OUT_LAT_NS / `PGCE_CLK_PERIOD_NS)
`define PGCE_TOG_LAT_NS     30
`define PGCE_TOG_LAT_CYC    (`PGCE_TOG_LAT_NS / `PGCE_CLK_PERIOD_NS)
`define PGCE_CAP_LAT_NS     65
`define PGCE_DLY_DEPTH      4
`define PGCE_STS_TS_LSB     0
`define PGCE_STS_TS_W       6
`define PGCE_STS_TIMER_A    8
`define PGCE_STS_TIMER_B    9
`define PGCE_STS_RISE_LSB   16
`define PGCE_STS_FALL_LSB   24
`define PGCE_STS_RESET      32'h0000_0000
`define PGCE_CAP_RESET      32'h0000_0000
`endif

// ==== design/pgce_pkg.sv ====
// types shared by the pin capture/event block
package pgce_pkg;
  typedef enum logic [1:0] {
    PGCE_MODE_PULSE  = 2'h0,
    PGCE_MODE_TOGGLE = 2'h1,
    PGCE_MODE_FLAG   = 2'h2
  } pgce_mode_t;
  typedef logic [31:0] pgce_word_t;
endpackage : pgce_pkg

// ==== design/pgce_capture_event.sv ====
// pin time capture, timer flag clearing, compare event outputs and unit summary event
`include "pgce_defines.svh"

module pgce_capture_event
  import pgce_pkg::*;
#(
  parameter int PINS  = 8,
  parameter int SEC_W = 32,
  parameter int NS_W  = 32
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // running time of day
  input  wire logic [SEC_W-1:0]           tod_seconds,
  input  wire logic [NS_W-1:0]            tod_nanoseconds,
  // compare targets, channel A then B
  input  wire logic [1:0][SEC_W-1:0]      target_seconds,
  input  wire logic [1:0][NS_W-1:0]       target_nanoseconds,
  // pins
  input  wire logic [PINS-1:0]            pin_in,
  output logic      [PINS-1:0]            pin_out,
  output logic      [PINS-1:0]            pin_oe_n,
  // pin configuration
  input  wire logic [PINS-1:0]            pin_direction_out,
  input  wire logic [PINS-1:0]            pin_data_out,
  input  wire logic [PINS-1:0]            pin_buffer_type,
  input  wire logic [PINS-1:0]            pin_polarity_bits,
  input  wire logic [PINS-1:0]            event_output_enables,
  input  wire logic [PINS-1:0]            event_channel_selects,
  // capture configuration
  input  wire logic [PINS-1:0]            rise_capture_enables,
  input  wire logic [PINS-1:0]            fall_capture_enables,
  input  wire logic [PINS-1:0]            rise_capture_lock,
  input  wire logic [PINS-1:0]            fall_capture_lock,
  // general configuration
  input  wire logic [1:0]                 timer_clear_enable,
  input  wire logic [1:0][2:0]            timer_clear_select,
  input  wire pgce_mode_t                 event_mode_a,
  input  wire pgce_mode_t                 event_mode_b,
  // command
  input  wire logic                       manual_capture_cmd,
  input  wire logic [3:0]                 manual_capture_select,
  // interrupt status and enable
  input  wire logic [`PGCE_STS_TS_W-1:0]  timestamp_events,
  input  wire pgce_word_t                 ptp_irq_clear,
  input  wire pgce_word_t                 ptp_irq_enable,
  output pgce_word_t                      ptp_irq_status,
  output logic                            ptp_summary_event,
  output logic      [PINS-1:0]            pin_edge_events,
  // capture registers
  output logic [7:0][SEC_W-1:0]           rise_capture_seconds,
  output logic [7:0][NS_W-1:0]            rise_capture_nanoseconds,
  output logic [7:0][SEC_W-1:0]           fall_capture_seconds,
  output logic [7:0][NS_W-1:0]            fall_capture_nanoseconds
);

  localparam int STABLE_CYC = `PGCE_STABLE_CYC;
  localparam int PULSE_CYC  = `PGCE_PULSE_CYC;
  // each tap is the latency less three fixed register stages
  localparam int PULSE_TAP  = `PGCE_OUT_LAT_CYC - 3;
  localparam int TOG_TAP    = `PGCE_TOG_LAT_CYC - 3;
  localparam int FLAG_TAP   = `PGCE_OUT_LAT_CYC - 3;

  function automatic logic time_reached(input logic [SEC_W-1:0] sec,
                                        input logic [NS_W-1:0]  ns,
                                        input logic [SEC_W-1:0] tsec,
                                        input logic [NS_W-1:0]  tns);
    time_reached = (sec > tsec) || ((sec == tsec) && (ns >= tns));
  endfunction : time_reached

  // one-hot pick of a capture set for a manual command
  function automatic logic [7:0] set_pick(input logic       hit,
                                          input logic [2:0] idx);
    set_pick = hit ? (8'h01 << idx) : 8'h00;
  endfunction : set_pick

  // a set flag with its lock refuses pin loads; manual loads always pass
  function automatic logic [7:0] load_gate(input logic [7:0] pin_ev,
                                           input logic [7:0] lock,
                                           input logic [7:0] flags,
                                           input logic [7:0] man);
    load_gate = (pin_ev & ~(lock & flags)) | man;
  endfunction : load_gate

  // synchroniser and stability filter
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] filt;
  logic [2:0]      stab_cnt [PINS];
  logic [PINS-1:0] differs;
  logic [PINS-1:0] settle;
  logic [PINS-1:0] active_now;
  logic [PINS-1:0] is_input;
  logic [PINS-1:0] act_rise;
  logic [PINS-1:0] act_fall;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  assign differs = sync_b ^ filt;

  // the edge is taken from the cycle the filter flips, saving one stage of latency
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      settle[i] = differs[i] && (stab_cnt[i] == 3'(STABLE_CYC - 1));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= '0;
      for (int i = 0; i < PINS; i++) begin
        stab_cnt[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (!differs[i] || settle[i]) begin
          stab_cnt[i] <= 3'h0;
        end else begin
          stab_cnt[i] <= stab_cnt[i] + 3'h1;
        end
        if (settle[i]) begin
          filt[i] <= sync_b[i];
        end
      end
    end
  end

  assign active_now = sync_b ^ pin_polarity_bits;
  assign is_input   = ~(pin_direction_out | event_output_enables);
  assign act_rise   = settle & active_now & is_input;
  assign act_fall   = settle & ~active_now & is_input;

  // ordinary pin interrupt source; manual captures never reach it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_edge_events <= '0;
    end else begin
      pin_edge_events <= act_rise | act_fall;
    end
  end

  // capture decode
  logic [7:0] rise_flags;
  logic [7:0] fall_flags;
  logic [7:0] man_rise;
  logic [7:0] man_fall;
  logic [7:0] pin_rise_ev;
  logic [7:0] pin_fall_ev;
  logic [7:0] rise_load;
  logic [7:0] fall_load;

  assign man_rise = set_pick(manual_capture_cmd && !manual_capture_select[3],
                             manual_capture_select[2:0]);
  assign man_fall = set_pick(manual_capture_cmd && manual_capture_select[3],
                             manual_capture_select[2:0]);
  assign pin_rise_ev = 8'(act_rise & rise_capture_enables);
  assign pin_fall_ev = 8'(act_fall & fall_capture_enables);
  // lock only guards pin edges; manual always writes
  assign rise_load = load_gate(pin_rise_ev, 8'(rise_capture_lock),
                               rise_flags, man_rise);
  assign fall_load = load_gate(pin_fall_ev, 8'(fall_capture_lock),
                               fall_flags, man_fall);

  // both halves latched on one edge from one sample keep the pair coherent
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_capture_seconds     <= '0;
      rise_capture_nanoseconds <= '0;
      fall_capture_seconds     <= '0;
      fall_capture_nanoseconds <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (rise_load[i]) begin
          rise_capture_seconds[i]     <= tod_seconds;
          rise_capture_nanoseconds[i] <= tod_nanoseconds;
        end
        if (fall_load[i]) begin
          fall_capture_seconds[i]     <= tod_seconds;
          fall_capture_nanoseconds[i] <= tod_nanoseconds;
        end
      end
    end
  end

  // compare channels
  logic [1:0] reached;
  logic [1:0] reached_q;
  logic [1:0] cmp_event;
  logic [1:0] timer_flags;
  logic [1:0] pin_clear;

  assign reached[0] = time_reached(tod_seconds, tod_nanoseconds,
                                   target_seconds[0], target_nanoseconds[0]);
  assign reached[1] = time_reached(tod_seconds, tod_nanoseconds,
                                   target_seconds[1], target_nanoseconds[1]);
  assign cmp_event  = reached & ~reached_q;
  // only the active-going edge clears; the release edge is ignored
  assign pin_clear[0] = timer_clear_enable[0] && act_rise[timer_clear_select[0]];
  assign pin_clear[1] = timer_clear_enable[1] && act_rise[timer_clear_select[1]];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reached_q <= 2'h0;
    end else begin
      reached_q <= reached;
    end
  end

  // status register; a set in the same cycle as a clear wins
  pgce_word_t sts_set;
  pgce_word_t sts_clr;

  always_comb begin
    sts_set = '0;
    sts_set[`PGCE_STS_TS_LSB +: `PGCE_STS_TS_W] = timestamp_events;
    sts_set[`PGCE_STS_TIMER_A] = cmp_event[0];
    sts_set[`PGCE_STS_TIMER_B] = cmp_event[1];
    sts_set[`PGCE_STS_RISE_LSB +: 8] = pin_rise_ev | man_rise;
    sts_set[`PGCE_STS_FALL_LSB +: 8] = pin_fall_ev | man_fall;
    sts_clr = ptp_irq_clear;
    sts_clr[`PGCE_STS_TIMER_A] = ptp_irq_clear[`PGCE_STS_TIMER_A] | pin_clear[0];
    sts_clr[`PGCE_STS_TIMER_B] = ptp_irq_clear[`PGCE_STS_TIMER_B] | pin_clear[1];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptp_irq_status <= `PGCE_STS_RESET;
    end else begin
      ptp_irq_status <= (ptp_irq_status & ~sts_clr) | sts_set;
    end
  end

  assign rise_flags  = ptp_irq_status[`PGCE_STS_RISE_LSB +: 8];
  assign fall_flags  = ptp_irq_status[`PGCE_STS_FALL_LSB +: 8];
  assign timer_flags = {ptp_irq_status[`PGCE_STS_TIMER_B], ptp_irq_status[`PGCE_STS_TIMER_A]};
  assign ptp_summary_event = |(ptp_irq_status & ptp_irq_enable);

  // event channel waveforms, delayed to meet the output latency
  logic [`PGCE_DLY_DEPTH-1:0] ev_dly   [2];
  logic [`PGCE_DLY_DEPTH-1:0] flag_dly [2];
  logic [3:0]                 pulse_cnt [2];
  logic [1:0]                 toggle_q;
  logic [1:0]                 chan_level;
  pgce_mode_t                 chan_mode [2];

  assign chan_mode[0] = event_mode_a;
  assign chan_mode[1] = event_mode_b;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        ev_dly[c]    <= '0;
        flag_dly[c]  <= '0;
        pulse_cnt[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        ev_dly[c]   <= {ev_dly[c][`PGCE_DLY_DEPTH-2:0], cmp_event[c]};
        flag_dly[c] <= {flag_dly[c][`PGCE_DLY_DEPTH-2:0], timer_flags[c]};
        // toggle runs in every mode, so a mode switch shows the last phase
        if (ev_dly[c][TOG_TAP]) begin
          toggle_q[c] <= ~toggle_q[c];
        end
        if (ev_dly[c][PULSE_TAP]) begin
          pulse_cnt[c] <= 4'(PULSE_CYC);
        end else if (pulse_cnt[c] != 4'h0) begin
          pulse_cnt[c] <= pulse_cnt[c] - 4'h1;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (chan_mode[c])
        PGCE_MODE_PULSE:  chan_level[c] = pulse_cnt[c] != 4'h0;
        PGCE_MODE_TOGGLE: chan_level[c] = toggle_q[c];
        PGCE_MODE_FLAG:   chan_level[c] = flag_dly[c][FLAG_TAP];
        default:          chan_level[c] = 1'b0;
      endcase
    end
  end

  // pin drivers
  logic [PINS-1:0] drive_val;
  logic [PINS-1:0] drive_want;

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      drive_val[i] = event_output_enables[i]
                     ? chan_level[event_channel_selects[i]] ^ pin_polarity_bits[i]
                     : pin_data_out[i];
    end
  end

  assign drive_want = pin_direction_out | event_output_enables;

  // open-drain only pulls low, whatever the source
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= drive_val & ~pin_buffer_type;
      pin_oe_n <= ~(drive_want & ~(pin_buffer_type & drive_val));
    end
  end

endmodule : pgce_capture_event

// ==== verification/pgce_capture_event_checker.sv ====
// port-level assertions for the pin capture/event block
`include "pgce_defines.svh"
module pgce_capture_event_checker
  import pgce_pkg::*;
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_n,
  // pin side, mode, lock and manual command
  input wire logic [7:0]       pin_out,
  input wire logic [7:0]       pin_oe_n,
  input wire logic [7:0]       pin_buffer_type,
  input wire logic [7:0]       pin_polarity_bits,
  input wire logic [7:0]       event_output_enables,
  input wire logic [7:0]       event_channel_selects,
  input wire logic [7:0]       rise_capture_lock,
  input wire pgce_mode_t       event_mode_a,
  input wire logic             manual_capture_cmd,
  // status and captures
  input wire pgce_word_t       ptp_irq_enable,
  input wire pgce_word_t       ptp_irq_status,
  input wire logic             ptp_summary_event,
  input wire logic [7:0]       pin_edge_events,
  input wire logic [7:0][31:0] rise_capture_nanoseconds
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // pin 0 as plain active-high push-pull output of channel A
  wire pin0_a = event_output_enables[0] & ~event_channel_selects[0] & ~pin_buffer_type[0]
    & ~pin_polarity_bits[0];
  wire flag_a = ptp_irq_status[`PGCE_STS_TIMER_A];
  chk_summary_or: assert property (
    ptp_summary_event == |(ptp_irq_status & ptp_irq_enable))
    else $error("summary event wrong");
  chk_pulse_width: assert property (
    pin0_a && event_mode_a == PGCE_MODE_PULSE && $rose(flag_a)
    |-> ##3 pin_out[0] [*8] ##1 pin_out[0] ##1 pin_out[0] ##1 !pin_out[0])
    else $error("pulse start or width wrong");
  chk_toggle_flip: assert property (
    pin0_a && event_mode_a == PGCE_MODE_TOGGLE && $rose(flag_a)
    |-> ##2 pin_out[0] != $past(pin_out[0], 2))
    else $error("toggle missing");
  chk_flag_follow: assert property (
    pin0_a && event_mode_a == PGCE_MODE_FLAG && $past(event_mode_a, 3) == PGCE_MODE_FLAG
    |-> pin_out[0] == $past(flag_a, 3))
    else $error("flag level output wrong");
  chk_oe_override: assert property (
    $past(rst_n) && event_output_enables[0] && !pin_buffer_type[0] |=> !pin_oe_n[0])
    else $error("event pin not driven");
  chk_open_drain: assert property (
    pin_buffer_type[1] && $past(pin_buffer_type[1]) |-> !pin_out[1])
    else $error("open-drain pin drives high");
  // manual answer may land one or two edges after the command
  chk_flag_cause: assert property (
    $rose(ptp_irq_status[`PGCE_STS_RISE_LSB])
    |-> pin_edge_events[0] || $past(manual_capture_cmd) || $past(manual_capture_cmd, 2))
    else $error("rise flag set without cause");
  chk_lock_hold: assert property (
    rise_capture_lock[0] && ptp_irq_status[`PGCE_STS_RISE_LSB] && !manual_capture_cmd
    && !$past(manual_capture_cmd) |=> $stable(rise_capture_nanoseconds[0]))
    else $error("locked capture overwritten");
  chk_edge_spacing: assert property (
    pin_edge_events[2] |=> !pin_edge_events[2] [*4])
    else $error("pin edges too close");
  cov_pulse: cover property (event_mode_a == PGCE_MODE_PULSE && pin_out[0]);
  cov_lock: cover property (rise_capture_lock[0] && ptp_irq_status[16]);
  cov_manual: cover property (manual_capture_cmd);
endmodule : pgce_capture_event_checker

bind pgce_capture_event pgce_capture_event_checker u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_buffer_type(pin_buffer_type), .pin_polarity_bits(pin_polarity_bits),
  .event_output_enables(event_output_enables), .event_channel_selects(event_channel_selects),
  .rise_capture_lock(rise_capture_lock), .event_mode_a(event_mode_a),
  .manual_capture_cmd(manual_capture_cmd), .ptp_irq_enable(ptp_irq_enable),
  .ptp_irq_status(ptp_irq_status), .ptp_summary_event(ptp_summary_event),
  .pin_edge_events(pin_edge_events), .rise_capture_nanoseconds(rise_capture_nanoseconds)
);

// ==== verification/pgce_pin_source.sv ====
// external signal sources on the input pins
module pgce_pin_source (
  // clock and driven levels
  input  wire logic       sys_clk,
  output logic      [7:0] pin_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_drv = 8'h00;
  task automatic set_pin(input int p, input logic lvl, input int hold);
    @(posedge sys_clk);
    #1 pin_drv[p] = lvl;
    repeat (hold) @(posedge sys_clk);
    if (hold > 0) #1;
  endtask : set_pin
endmodule : pgce_pin_source

// ==== verification/testbench.sv ====
// self-checking bench for the pin capture/event block
module testbench
  import pgce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             sys_clk, summ;
  logic             rst_n = 1'b0, cmd = 1'b0;
  logic [31:0]      tsec = 32'h00000005, tns = 32'h00000000;
  logic [1:0][31:0] tgt_s = '1, tgt_ns = '1;
  logic [7:0]       pin_in, pin_out, pin_oe_n, pin_drv, edges;
  logic [7:0]       dir = '0, dat = '0, od = '0, pol = '0, eoe = '0, esel = '0;
  logic [7:0]       re_en = '0, fe_en = '0, re_lk = '0, fe_lk = '0;
  logic [1:0]       clr_en = '0;
  logic [1:0][2:0]  clr_sel = '0;
  pgce_mode_t       mode_a = PGCE_MODE_PULSE, mode_b = PGCE_MODE_FLAG;
  logic [3:0]       msel = '0;
  logic [5:0]       ts_ev = '0;
  pgce_word_t       irq_clr = '0, irq_en = '0, sts;
  logic [7:0][31:0] rs, rn, fs, fn;
  int               failures = 0, n_compared = 0;
  pgce_capture_event dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .tod_seconds(tsec), .tod_nanoseconds(tns),
    .target_seconds(tgt_s), .target_nanoseconds(tgt_ns), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_direction_out(dir), .pin_data_out(dat), .pin_buffer_type(od),
    .pin_polarity_bits(pol), .event_output_enables(eoe), .event_channel_selects(esel),
    .rise_capture_enables(re_en), .fall_capture_enables(fe_en), .rise_capture_lock(re_lk),
    .fall_capture_lock(fe_lk), .timer_clear_enable(clr_en), .timer_clear_select(clr_sel),
    .event_mode_a(mode_a), .event_mode_b(mode_b), .manual_capture_cmd(cmd),
    .manual_capture_select(msel), .timestamp_events(ts_ev), .ptp_irq_clear(irq_clr),
    .ptp_irq_enable(irq_en), .ptp_irq_status(sts), .ptp_summary_event(summ),
    .pin_edge_events(edges), .rise_capture_seconds(rs), .rise_capture_nanoseconds(rn),
    .fall_capture_seconds(fs), .fall_capture_nanoseconds(fn)
  );
  pgce_pin_source src (.sys_clk(sys_clk), .pin_drv(pin_drv));
  // wire level: the block wins where it drives, the source elsewhere
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pin_drv);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // time advances just after each edge, like every other input
  always @(posedge sys_clk) tns <= #1 tns + 32'h0000000a;
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic pin_cap(input int p, input logic lvl, input logic rise, input logic blk);
    logic [31:0] t0, old;
    int          k;
    old = rise ? rn[p] : fn[p];
    src.set_pin(p, lvl, 0);
    t0 = tns;
    for (k = 0; k < 20 && edges[p] !== 1'b1; k++) tick(1);
    cmp("edge_seen", 1, edges[p]);
    if (blk) cmp("locked_ns", old, rn[p]);
    else cmp("latency", 1, ((rise ? rn[p] : fn[p]) - t0) inside {[60:80]});
    cmp("cap_sec", tsec, rise ? rs[p] : fs[p]);
    cmp("cap_flag", 1, sts[(rise ? 16 : 24) + p]);
    tick(6);
  endtask : pin_cap
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #60000;
    failures++;
    final_report();
  end
  initial begin
    logic [31:0] t0, got;
    logic [7:0]  old;
    repeat (3) @(posedge sys_clk);
    #1;
    cmp("sts_rst", 32'h0, sts);
    cmp("oe_rst", 32'hff, pin_oe_n);
    rst_n = 1'b1;
    re_en = 8'h04;
    fe_en = 8'h04;
    irq_en = 32'h00040000;
    pin_cap(2, 1'b1, 1'b1, 1'b0);
    cmp("summary", 1, summ);
    pin_cap(2, 1'b0, 1'b0, 1'b0);
    src.set_pin(3, 1'b1, 8);
    pol = 8'h08;
    re_en = 8'h0c;
    tick(8);
    pin_cap(3, 1'b0, 1'b1, 1'b0);
    re_lk = 8'h04;
    pin_cap(2, 1'b1, 1'b1, 1'b1);
    irq_clr = 32'h00040000;
    tick(1);
    irq_clr = '0;
    src.set_pin(2, 1'b0, 8);
    pin_cap(2, 1'b1, 1'b1, 1'b0);
    irq_clr = 32'h00040000;
    tick(1);
    irq_clr = '0;
    src.set_pin(2, 1'b0, 2);
    src.set_pin(2, 1'b1, 10);
    cmp("glitch", 0, sts[18]);
    re_lk = '1;
    for (int s = 0; s < 16; s++) begin
      t0 = tns;
      msel = 4'(s);
      cmd = 1'b1;
      tick(1);
      cmd = 1'b0;
      tick(3);
      got = s[3] ? fn[s[2:0]] : rn[s[2:0]];
      cmp("man_ns", 1, got == t0 + 32'h0a || got == t0 + 32'h14);
      cmp("man_flag", 1, sts[16 + s]);
      cmp("man_quiet", 0, edges);
    end
    tsec = 32'h00000006;
    eoe = 8'h03;
    esel = 8'h02;
    pol = 8'h02;
    od = 8'h02;
    clr_en = 2'b01;
    clr_sel[0] = 3'h4;
    tick(4);
    cmp("od_idle", 2'b10, {pin_oe_n[1], pin_out[1]});
    for (int m = 0; m < 3; m++) begin
      mode_a = pgce_mode_t'(m);
      tick(4);
      old = pin_out;
      tgt_s[0] = tsec;
      tgt_ns[0] = tns + 32'h28;
      tick(9);
      cmp("timer_a", 1, sts[8]);
      cmp("ev_on", m == 1 ? !old[0] : 1'b1, pin_out[0]);
      tick(12);
      cmp("ev_late", m == 0 ? 1'b0 : (m == 1 ? !old[0] : 1'b1), pin_out[0]);
      src.set_pin(4, 1'b1, 12);
      tgt_s[0] = '1;
      cmp("timer_clr", 0, sts[8]);
      cmp("ev_clr", m == 1 ? !old[0] : 1'b0, pin_out[0]);
      src.set_pin(4, 1'b0, 8);
    end
    tgt_s[1] = tsec;
    tgt_ns[1] = tns + 32'h28;
    tick(12);
    cmp("timer_b", 1, sts[9]);
    cmp("ev_b", 2'b00, {pin_oe_n[1], pin_out[1]});
    cmp("ev_a", 0, pin_out[0]);
    irq_en = 32'h00000020;
    tick(1);
    cmp("summary_off", 0, summ);
    ts_ev = 6'h3f;
    tick(1);
    ts_ev = 6'h01;
    irq_clr = 32'h0000003f;
    cmp("ts_flags", 32'h3f, sts & 32'h3f);
    cmp("summary_on", 1, summ);
    tick(1);
    ts_ev = '0;
    irq_clr = '0;
    cmp("set_wins", 32'h01, sts & 32'h3f);
    final_report();
  end
endmodule : testbench
